// file: core/lfd_params.svh
// Named constants for the loop detector channel: clock rate, times and status line widths.
`ifndef LFD_PARAMS_SVH
`define LFD_PARAMS_SVH

// Reference clock and the 1 ms tick that paces every slow timer.
`define LFD_CLK_HZ 100000000
`define LFD_TICKS_PER_S 1000

// Presence limits in minutes and the minute length in ticks.
`define LFD_SHORT_PRES_MIN 30
`define LFD_LONG_PRES_MIN 120
`define LFD_MS_PER_MIN 60000

// Pulse mode call width in ms.
`define LFD_PULSE_MS 125

// Delay in ms from an inductance change until the retune.
`define LFD_RETUNE_MS 2000

// Flash code timing in ms: lamp on, lamp off between flashes, pause after a code.
`define LFD_FLASH_ON_MS 250
`define LFD_FLASH_OFF_MS 250
`define LFD_FLASH_GAP_MS 1000

// Frequency readout: time each symbol stays up in ms and how often the sequence repeats.
`define LFD_DISP_STEP_MS 1000
`define LFD_DISP_PASSES 3
`define LFD_DISP_LAST_STEP 4

// Status line frame period and low-pulse width per fault code, all in ms.
`define LFD_STAT_PERIOD_MS 1000
`define LFD_STAT_WD_MS 100
`define LFD_STAT_OPEN_MS 200
`define LFD_STAT_SHORT_MS 300
`define LFD_STAT_CHANGE_MS 400

`endif

// file: core/lfd_pkg.sv
// Types shared by the loop detector channel and its flash code generator.
package lfd_pkg;

  typedef enum logic [2:0] {
    LFD_MODE_PRES_S = 3'b000,
    LFD_MODE_PRES_L = 3'b001,
    LFD_MODE_PULSE = 3'b010,
    LFD_MODE_CALL = 3'b011,
    LFD_MODE_OFF = 3'b100
  } lfd_mode_e;

  // The code value doubles as the number of flashes in the fault sequence.
  typedef enum logic [1:0] {
    LFD_FLT_NONE = 2'b00,
    LFD_FLT_OPEN = 2'b01,
    LFD_FLT_SHORT = 2'b10,
    LFD_FLT_CHANGE = 2'b11
  } lfd_fault_e;

  typedef enum logic [1:0] {
    LFD_SYM_BLANK = 2'b00,
    LFD_SYM_DIGIT = 2'b01,
    LFD_SYM_DASH = 2'b10,
    LFD_SYM_FAULT = 2'b11
  } lfd_sym_e;

  typedef enum logic [1:0] {
    LFD_FL_IDLE = 2'b00,
    LFD_FL_ON = 2'b01,
    LFD_FL_OFF = 2'b10,
    LFD_FL_GAP = 2'b11
  } lfd_flash_state_e;

  typedef struct packed {
    logic open;
    logic shorted;
    logic change;
  } lfd_loop_fault_s;

  typedef struct packed {
    logic [1:0] level;
    logic [3:0] tens;
    logic [3:0] ones;
  } lfd_frequency_select_button_s;

  typedef struct packed {
    lfd_sym_e sym;
    logic [3:0] digit;
  } lfd_disp_s;

endpackage

// file: core/lfd_flasher.sv
// Flash code generator: repeats a burst of one to three flashes followed by a pause.
`timescale 1ns/1ns
`include "lfd_params.svh"
module lfd_flasher (
  input wire logic ref_clk, // Reference clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic tick_ms, // One-cycle pulse every millisecond.
  input wire logic [1:0] count, // Flashes per burst; zero stops the lamp.
  output logic led // Lamp drive, high while lit.
);

  localparam logic [11:0] ON_MS = 12'(`LFD_FLASH_ON_MS);
  localparam logic [11:0] OFF_MS = 12'(`LFD_FLASH_OFF_MS);
  localparam logic [11:0] GAP_MS = 12'(`LFD_FLASH_GAP_MS);

  lfd_pkg::lfd_flash_state_e state_q, state_d;
  logic [11:0] ms_q, ms_d;
  logic [1:0] num_q, num_d;
  logic [1:0] cnt_q, cnt_d;
  logic led_q, led_d;

  // The count is taken only at the start of a burst, so only a change of the count to zero can cut a sequence short.
  always_comb begin
    state_d = state_q;
    ms_d = ms_q;
    num_d = num_q;
    cnt_d = cnt_q;
    if (tick_ms) begin
      ms_d = ms_q + 12'h001;
    end
    case (state_q)
      lfd_pkg::LFD_FL_IDLE: begin
        if (count != 2'h0) begin
          state_d = lfd_pkg::LFD_FL_ON;
          cnt_d = count;
          num_d = 2'h1;
          ms_d = 12'h000;
        end
      end
      lfd_pkg::LFD_FL_ON: begin
        if (ms_q >= ON_MS) begin
          ms_d = 12'h000;
          state_d = (num_q == cnt_q) ? lfd_pkg::LFD_FL_GAP : lfd_pkg::LFD_FL_OFF;
        end
      end
      lfd_pkg::LFD_FL_OFF: begin
        if (ms_q >= OFF_MS) begin
          ms_d = 12'h000;
          num_d = num_q + 2'h1;
          state_d = lfd_pkg::LFD_FL_ON;
        end
      end
      lfd_pkg::LFD_FL_GAP: begin
        if (ms_q >= GAP_MS) begin
          ms_d = 12'h000;
          state_d = lfd_pkg::LFD_FL_IDLE;
        end
      end
      default: begin
        state_d = lfd_pkg::LFD_FL_IDLE;
      end
    endcase
    if (count == 2'h0) begin
      state_d = lfd_pkg::LFD_FL_IDLE;
    end
    led_d = (state_d == lfd_pkg::LFD_FL_ON);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= lfd_pkg::LFD_FL_IDLE;
      ms_q <= 12'h000;
      num_q <= 2'h0;
      cnt_q <= 2'h0;
      led_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ms_q <= ms_d;
      num_q <= num_d;
      cnt_q <= cnt_d;
      led_q <= led_d;
    end
  end

  assign led = led_q;

endmodule

// file: core/lfd_channel.sv
// One detector channel: output modes, loop fault classification, indicators, display and status line.
// Function
// R1 - Frequency button starts a display cycle: level digit, dash, kHz digits, dash.
// R2 - Loop is watched continuously for open, short and sudden inductance change faults.
// R3 - While a fault is present, output and fault lamps repeat its flash code.
// R4 - While a fault is present the display shows the fault letter.
// R5 - Open gives one flash, short two, inductance change three.
// R6 - A healed open or short returns detect lamp and display to normal.
// R7 - After a fault clears the fault lamp keeps the last code; output lamp stops.
// R8 - Inductance change retunes two seconds later; fault lamp keeps its code.
// R9 - Mode button selects presence, pulse, continuous call or channel off.
// R10 - Presence has a short 30 minute and a long 120 minute variant.
// R11 - Pulse mode gives one 125 ms call pulse per arriving vehicle.
// R12 - Call mode holds the call output on without a break.
// R13 - Channel off drops detection and stops the loop oscillator.
// R14 - An option holds the status output on while the channel is off.
// R15 - Status output is held on (low) in normal operation.
// R16 - Faults go out on the status line as pulse-width codes, 10 ms accuracy.
// R17 - Each status code width is its own named constant.
// R18 - Presence call follows the vehicle and drops when the time limit runs out.
// R19 - Frequency readout is in kHz with a dash before and after the digits.
`timescale 1ns/1ns
`include "lfd_params.svh"
module lfd_channel #(
  parameter int TICK_CYCLES = `LFD_CLK_HZ / `LFD_TICKS_PER_S // Clock cycles per 1 ms tick.
) (
  input wire logic ref_clk, // 100 MHz reference clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic frequency_select_button, // Front panel pin, high while pressed.
  input wire logic mode_button, // Front panel pin, high while pressed.
  input wire logic vehicle_present, // Loop sensing says a vehicle is over the loop.
  input wire lfd_pkg::lfd_loop_fault_s loop_fault, // Loop sensing fault levels.
  input wire lfd_pkg::lfd_frequency_select_button_s frequency_select_button_info, // Frequency level and loop frequency in kHz.
  input wire logic [3:0] call_strength, // Digit for the normal readout.
  input wire logic status_on_when_off, // Keep status line on while the channel is off.
  input wire logic supply_fail, // Watchdog or supply failure.
  output logic call_out, // Call to the controller, high is a call.
  output logic output_indicator, // Output lamp.
  output logic detect_indicator, // Detect lamp.
  output logic fault_indicator, // Fault lamp.
  output lfd_pkg::lfd_disp_s display, // Front display symbol.
  output logic osc_enable, // Loop oscillator enable.
  output logic retune, // One-cycle retune request.
  output lfd_pkg::lfd_mode_e mode, // Current output mode.
  output logic status_out_n // Status line to the bus interface unit, low is on.
);

  localparam int DIV_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);
  localparam logic [22:0] SHORT_LIM = 23'(`LFD_SHORT_PRES_MIN * `LFD_MS_PER_MIN);
  localparam logic [22:0] LONG_LIM = 23'(`LFD_LONG_PRES_MIN * `LFD_MS_PER_MIN);
  localparam logic [22:0] PULSE_LIM = 23'(`LFD_PULSE_MS);
  localparam logic [10:0] RETUNE_LIM = 11'(`LFD_RETUNE_MS);
  localparam logic [9:0] STEP_LIM = 10'(`LFD_DISP_STEP_MS);
  localparam logic [9:0] STAT_LAST = 10'(`LFD_STAT_PERIOD_MS - 1);

  // Low-pulse width of the status frame; supply failure outranks loop faults.
  function automatic logic [9:0] stat_width(input logic wd, input lfd_pkg::lfd_fault_e f);
    logic [9:0] w;
    w = 10'h000;
    if (wd) begin
      w = 10'(`LFD_STAT_WD_MS);
    end else begin
      case (f)
        lfd_pkg::LFD_FLT_OPEN: w = 10'(`LFD_STAT_OPEN_MS);
        lfd_pkg::LFD_FLT_SHORT: w = 10'(`LFD_STAT_SHORT_MS);
        lfd_pkg::LFD_FLT_CHANGE: w = 10'(`LFD_STAT_CHANGE_MS);
        default: w = 10'h000;
      endcase
    end
    return w;
  endfunction

  // Button pins: two flops before anything looks at them, then a third for the edge.
  logic [1:0] fbtn_q, mbtn_q;
  logic fbtn_prev_q, mbtn_prev_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fbtn_q <= 2'h0;
      mbtn_q <= 2'h0;
      fbtn_prev_q <= 1'b0;
      mbtn_prev_q <= 1'b0;
    end else begin
      fbtn_q <= {fbtn_q[0], frequency_select_button};
      mbtn_q <= {mbtn_q[0], mode_button};
      fbtn_prev_q <= fbtn_q[1];
      mbtn_prev_q <= mbtn_q[1];
    end
  end
  logic fpress, mpress;
  assign fpress = fbtn_q[1] & ~fbtn_prev_q;
  assign mpress = mbtn_q[1] & ~mbtn_prev_q;

  // Millisecond tick divider.
  logic [DIV_W-1:0] div_q, div_d;
  logic tick_q, tick_d;
  always_comb begin
    tick_d = (div_q == DIV_LAST);
    div_d = tick_d ? '0 : div_q + DIV_W'(1);
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  // Mode selection; each channel instance keeps its own.
  lfd_pkg::lfd_mode_e mode_q, mode_d;
  always_comb begin
    mode_d = mode_q;
    if (mpress) begin // R9
      case (mode_q)
        lfd_pkg::LFD_MODE_PRES_S: mode_d = lfd_pkg::LFD_MODE_PRES_L; // R10
        lfd_pkg::LFD_MODE_PRES_L: mode_d = lfd_pkg::LFD_MODE_PULSE;
        lfd_pkg::LFD_MODE_PULSE: mode_d = lfd_pkg::LFD_MODE_CALL;
        lfd_pkg::LFD_MODE_CALL: mode_d = lfd_pkg::LFD_MODE_OFF;
        default: mode_d = lfd_pkg::LFD_MODE_PRES_S;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= lfd_pkg::LFD_MODE_PRES_S;
    end else begin
      mode_q <= mode_d;
    end
  end
  logic ch_on;
  assign ch_on = (mode_q != lfd_pkg::LFD_MODE_OFF);

  // Fault classification. Open and short follow the sensing levels, so they heal by themselves;
  // an inductance change is an event that stays current until the retune.
  logic chg_q, chg_d;
  logic [10:0] chg_ms_q, chg_ms_d;
  logic retune_q, retune_d;
  lfd_pkg::lfd_fault_e cur_fault, last_q, last_d;
  always_comb begin
    if (!ch_on) begin
      cur_fault = lfd_pkg::LFD_FLT_NONE;
    end else if (loop_fault.open) begin // R2
      cur_fault = lfd_pkg::LFD_FLT_OPEN;
    end else if (loop_fault.shorted) begin // R2
      cur_fault = lfd_pkg::LFD_FLT_SHORT;
    end else if (chg_q) begin // R2
      cur_fault = lfd_pkg::LFD_FLT_CHANGE;
    end else begin
      cur_fault = lfd_pkg::LFD_FLT_NONE;
    end
    chg_d = chg_q;
    chg_ms_d = chg_ms_q;
    retune_d = 1'b0;
    if (chg_q && tick_q) begin
      chg_ms_d = chg_ms_q + 11'h001;
    end
    if (chg_q && chg_ms_q >= RETUNE_LIM) begin // R8
      chg_d = 1'b0;
      retune_d = 1'b1;
    end
    // A fresh change restarts the wait, so the retune lands on the latest inductance.
    if (ch_on && loop_fault.change) begin
      chg_d = 1'b1;
      chg_ms_d = 11'h000;
    end
    if (!ch_on) begin
      chg_d = 1'b0;
    end
    last_d = (cur_fault != lfd_pkg::LFD_FLT_NONE) ? cur_fault : last_q; // R7
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      chg_q <= 1'b0;
      chg_ms_q <= 11'h000;
      retune_q <= 1'b0;
      last_q <= lfd_pkg::LFD_FLT_NONE;
    end else begin
      chg_q <= chg_d;
      chg_ms_q <= chg_ms_d;
      retune_q <= retune_d;
      last_q <= last_d;
    end
  end
  logic faulted;
  assign faulted = (cur_fault != lfd_pkg::LFD_FLT_NONE);

  // Call output. A faulted channel calls, matching the fail-safe output, so traffic is not starved.
  logic veh;
  logic veh_q, call_q, call_d, pulse_q, pulse_d;
  logic [22:0] tmr_q, tmr_d;
  logic [22:0] pres_lim;
  assign veh = vehicle_present & ch_on & ~faulted;
  assign pres_lim = (mode_q == lfd_pkg::LFD_MODE_PRES_L) ? LONG_LIM : SHORT_LIM; // R10
  always_comb begin
    tmr_d = tmr_q;
    pulse_d = pulse_q;
    call_d = 1'b0;
    case (mode_q)
      lfd_pkg::LFD_MODE_PRES_S, lfd_pkg::LFD_MODE_PRES_L: begin
        pulse_d = 1'b0;
        if (!veh) begin
          tmr_d = 23'h000000;
        end else if (tmr_q < pres_lim) begin
          call_d = 1'b1; // R18
          if (tick_q) begin
            tmr_d = tmr_q + 23'h000001;
          end
        end
      end
      lfd_pkg::LFD_MODE_PULSE: begin
        if (veh && !veh_q) begin // R11
          pulse_d = 1'b1;
          tmr_d = 23'h000000;
        end else if (pulse_q) begin
          if (tmr_q >= PULSE_LIM) begin // R11
            pulse_d = 1'b0;
          end else if (tick_q) begin
            tmr_d = tmr_q + 23'h000001;
          end
        end
        call_d = pulse_d;
      end
      lfd_pkg::LFD_MODE_CALL: begin
        call_d = 1'b1; // R12
        pulse_d = 1'b0;
      end
      default: begin
        call_d = 1'b0; // R13
        pulse_d = 1'b0;
        tmr_d = 23'h000000;
      end
    endcase
    if (mode_d != mode_q) begin
      tmr_d = 23'h000000;
      pulse_d = 1'b0;
    end
    if (faulted) begin
      call_d = 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      veh_q <= 1'b0;
      call_q <= 1'b0;
      pulse_q <= 1'b0;
      tmr_q <= 23'h000000;
    end else begin
      veh_q <= veh;
      call_q <= call_d;
      pulse_q <= pulse_d;
      tmr_q <= tmr_d;
    end
  end

  // Two flash generators: the output lamp shows only a present fault, the fault lamp the last one.
  logic out_flash, flt_flash;
  lfd_flasher u_out_flash (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .tick_ms(tick_q),
    .count(cur_fault), // R3
    .led(out_flash)
  );
  lfd_flasher u_flt_flash (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .tick_ms(tick_q),
    .count(last_q), // R5
    .led(flt_flash)
  );

  logic oind_q, oind_d, dind_q, dind_d;
  always_comb begin
    oind_d = faulted ? out_flash : call_q; // R3
    dind_d = veh; // R6
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      oind_q <= 1'b0;
      dind_q <= 1'b0;
    end else begin
      oind_q <= oind_d;
      dind_q <= dind_d;
    end
  end

  // Display sequencer for the frequency readout.
  logic seq_q, seq_d;
  logic [2:0] step_q, step_d;
  logic [1:0] pass_q, pass_d;
  logic [9:0] step_ms_q, step_ms_d;
  lfd_pkg::lfd_disp_s disp_q, disp_d;
  always_comb begin
    seq_d = seq_q;
    step_d = step_q;
    pass_d = pass_q;
    step_ms_d = step_ms_q;
    if (seq_q && tick_q) begin
      step_ms_d = step_ms_q + 10'h001;
    end
    if (seq_q && step_ms_q >= STEP_LIM) begin
      step_ms_d = 10'h000;
      if (step_q == 3'(`LFD_DISP_LAST_STEP)) begin
        step_d = 3'h0;
        if (pass_q == 2'(`LFD_DISP_PASSES - 1)) begin
          seq_d = 1'b0;
        end else begin
          pass_d = pass_q + 2'h1;
        end
      end else begin
        step_d = step_q + 3'h1;
      end
    end
    if (fpress) begin // R1
      seq_d = 1'b1;
      step_d = 3'h0;
      pass_d = 2'h0;
      step_ms_d = 10'h000;
    end
    disp_d.sym = lfd_pkg::LFD_SYM_DIGIT;
    disp_d.digit = call_strength;
    if (!ch_on) begin
      disp_d.sym = lfd_pkg::LFD_SYM_DASH;
      disp_d.digit = 4'h0;
    end
    if (seq_q) begin
      case (step_q)
        3'h0: disp_d.digit = {2'h0, frequency_select_button_info.level}; // R1
        3'h2: disp_d.digit = frequency_select_button_info.tens; // R19
        3'h3: disp_d.digit = frequency_select_button_info.ones; // R19
        default: begin
          disp_d.sym = lfd_pkg::LFD_SYM_DASH; // R19
          disp_d.digit = 4'h0;
        end
      endcase
      if (step_q == 3'h0 || step_q == 3'h2 || step_q == 3'h3) begin
        disp_d.sym = lfd_pkg::LFD_SYM_DIGIT;
      end
    end
    if (faulted) begin // R4
      disp_d.sym = lfd_pkg::LFD_SYM_FAULT;
      disp_d.digit = 4'h0;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      seq_q <= 1'b0;
      step_q <= 3'h0;
      pass_q <= 2'h0;
      step_ms_q <= 10'h000;
      disp_q <= '{sym: lfd_pkg::LFD_SYM_BLANK, digit: 4'h0};
    end else begin
      seq_q <= seq_d;
      step_q <= step_d;
      pass_q <= pass_d;
      step_ms_q <= step_ms_d;
      disp_q <= disp_d;
    end
  end

  // Status line: a fault sends a low pulse of code-specific width at the start of each frame.
  logic [9:0] frame_q, frame_d;
  logic [9:0] width;
  logic stat_q, stat_d;
  assign width = stat_width(supply_fail, cur_fault); // R17
  always_comb begin
    frame_d = frame_q;
    if (tick_q) begin
      frame_d = (frame_q == STAT_LAST) ? 10'h000 : frame_q + 10'h001;
    end
    if (width != 10'h000) begin
      stat_d = ~(frame_q < width); // R16
    end else if (!ch_on) begin
      stat_d = ~status_on_when_off; // R14
    end else begin
      stat_d = 1'b0; // R15
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      frame_q <= 10'h000;
      stat_q <= 1'b0;
    end else begin
      frame_q <= frame_d;
      stat_q <= stat_d;
    end
  end

  assign call_out = call_q;
  assign output_indicator = oind_q;
  assign detect_indicator = dind_q;
  assign fault_indicator = flt_flash; // R7
  assign display = disp_q;
  assign osc_enable = ch_on; // R13
  assign retune = retune_q;
  assign mode = mode_q;
  assign status_out_n = stat_q;

endmodule

// file: verification/lfd_channel_assertions.sv
// Concurrent properties watching the channel's ports.
`timescale 1ns/1ns
module lfd_channel_assertions #(
  parameter int TICK_CYCLES = 4 // Clock cycles per tick.
) (
  input wire logic ref_clk, // Clock.
  input wire logic nrst, // Reset, active low.
  input wire logic vehicle_present, // Vehicle level.
  input wire lfd_pkg::lfd_loop_fault_s loop_fault, // Fault levels.
  input wire logic status_on_when_off, // Status option.
  input wire logic supply_fail, // Supply failure.
  input wire logic call_out, // Call output.
  input wire lfd_pkg::lfd_disp_s display, // Display symbol.
  input wire logic osc_enable, // Oscillator enable.
  input wire logic retune, // Retune pulse.
  input wire lfd_pkg::lfd_mode_e mode, // Mode.
  input wire logic status_out_n // Status line.
);
  localparam int PW_LO = 124 * TICK_CYCLES;
  localparam int PW_HI = 127 * TICK_CYCLES;
  logic chg_q;
  logic clean_q;
  logic dirty_q;
  logic veh_q;
  logic [31:0] hi_q;
  wire logic clean = !loop_fault.open && !loop_fault.shorted && !supply_fail && !chg_q;
  // A pulse disturbed by a fault, a mode change or a new arrival is not held to the width.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      chg_q <= 1'b0;
      clean_q <= 1'b1;
      dirty_q <= 1'b0;
      veh_q <= 1'b0;
      hi_q <= 32'h0;
    end else begin
      chg_q <= loop_fault.change | (chg_q & !retune);
      clean_q <= clean;
      veh_q <= vehicle_present;
      dirty_q <= call_out & (dirty_q | !clean | (mode != lfd_pkg::LFD_MODE_PULSE) | (vehicle_present & !veh_q));
      hi_q <= call_out ? hi_q + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_mode_order;
    (mode != $past(mode)) |-> (mode == (($past(mode) == lfd_pkg::LFD_MODE_OFF) ? lfd_pkg::LFD_MODE_PRES_S :
      lfd_pkg::lfd_mode_e'($past(mode) + 3'h1)));
  endproperty
  a_mode_order: assert property (p_mode_order) else $error("Mode stepped out of order.");
  property p_osc;
    osc_enable == (mode != lfd_pkg::LFD_MODE_OFF);
  endproperty
  a_osc: assert property (p_osc) else $error("Oscillator enable disagrees with mode.");
  property p_off_call;
    (mode == lfd_pkg::LFD_MODE_OFF) && ($past(mode) == lfd_pkg::LFD_MODE_OFF) |-> !call_out;
  endproperty
  a_off_call: assert property (p_off_call) else $error("Call seen in channel off mode.");
  property p_call_mode;
    (mode == lfd_pkg::LFD_MODE_CALL) && ($past(mode) == lfd_pkg::LFD_MODE_CALL) |-> call_out;
  endproperty
  a_call_mode: assert property (p_call_mode) else $error("Call dropped in call mode.");
  property p_pulse_w;
    $fell(call_out) && !dirty_q |-> (hi_q >= PW_LO) && (hi_q <= PW_HI);
  endproperty
  a_pulse_w: assert property (p_pulse_w) else $error("Pulse call width out of range.");
  // Display and status are registered, so the condition must already hold one cycle before the look.
  property p_fault_disp;
    (loop_fault.open && (mode != lfd_pkg::LFD_MODE_OFF)) [*2] |-> display.sym == lfd_pkg::LFD_SYM_FAULT;
  endproperty
  a_fault_disp: assert property (p_fault_disp) else $error("Fault letter missing.");
  property p_normal_status;
    (clean_q && (mode != lfd_pkg::LFD_MODE_OFF)) [*2] |-> !status_out_n;
  endproperty
  a_normal_status: assert property (p_normal_status) else $error("Status line not on without fault.");
  property p_off_status;
    ($past(mode) == lfd_pkg::LFD_MODE_OFF) && !$past(supply_fail) |-> status_out_n == !$past(status_on_when_off);
  endproperty
  a_off_status: assert property (p_off_status) else $error("Status line wrong in off mode.");
  property p_retune;
    retune |-> chg_q ##1 !retune;
  endproperty
  a_retune: assert property (p_retune) else $error("Retune without change or longer than one cycle.");
endmodule

// file: verification/lfd_far_side.sv
// Controller and status receiver: measures call and status pulse widths in clock cycles.
`timescale 1ns/1ns
module lfd_far_side (
  input wire logic ref_clk, // Clock.
  input wire logic call_out, // Call from the channel.
  input wire logic status_out_n, // Status line, low is on.
  output logic [31:0] call_w, // Width of the last call.
  output logic [31:0] call_n, // Number of calls seen.
  output logic [31:0] stat_w // Width of the last status low pulse.
);
  logic [31:0] hc = 32'h0;
  logic [31:0] lc = 32'h0;
  logic call_q = 1'b0;
  logic stat_q = 1'b0;
  initial begin
    call_w = 32'h0;
    call_n = 32'h0;
    stat_w = 32'h0;
  end
  // A steady low status line is never recorded, only completed low pulses.
  always @(posedge ref_clk) begin
    call_q <= call_out;
    stat_q <= status_out_n;
    hc <= call_out ? hc + 32'h1 : 32'h0;
    lc <= status_out_n ? 32'h0 : lc + 32'h1;
    if (call_q && !call_out) call_w <= hc;
    if (call_out && !call_q) call_n <= call_n + 32'h1;
    if (status_out_n && !stat_q) stat_w <= lc;
  end
endmodule

// file: verification/lfd_channel_tb.sv
// Self-checking bench for one detector channel.
`timescale 1ns/1ns
module lfd_channel_tb;
  localparam int TK = 2;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic fsb = 1'b0;
  logic mb = 1'b0;
  logic veh = 1'b0;
  logic soo = 1'b0;
  logic sf = 1'b0;
  lfd_pkg::lfd_loop_fault_s lf = 3'h0;
  lfd_pkg::lfd_frequency_select_button_s fq = {2'h3, 4'h2, 4'h7};
  logic call_out, oi, di, fli, osc, rt, st_n;
  lfd_pkg::lfd_disp_s disp;
  lfd_pkg::lfd_mode_e mode;
  logic [31:0] call_w, call_n, stat_w, n0;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  lfd_pkg::lfd_sym_e syms [5] = '{lfd_pkg::LFD_SYM_DIGIT, lfd_pkg::LFD_SYM_DASH, lfd_pkg::LFD_SYM_DIGIT,
    lfd_pkg::LFD_SYM_DIGIT, lfd_pkg::LFD_SYM_DASH};
  logic [3:0] digs [5] = '{4'h3, 4'h0, 4'h2, 4'h7, 4'h0};
  lfd_channel #(.TICK_CYCLES(TK)) dut_u (.ref_clk(ref_clk), .nrst(nrst), .frequency_select_button(fsb),
    .mode_button(mb), .vehicle_present(veh), .loop_fault(lf), .frequency_select_button_info(fq), .call_strength(4'h5),
    .status_on_when_off(soo), .supply_fail(sf), .call_out(call_out), .output_indicator(oi),
    .detect_indicator(di), .fault_indicator(fli), .display(disp), .osc_enable(osc), .retune(rt),
    .mode(mode), .status_out_n(st_n));
  lfd_far_side far_u (.ref_clk(ref_clk), .call_out(call_out), .status_out_n(st_n), .call_w(call_w),
    .call_n(call_n), .stat_w(stat_w));
  initial forever #5 ref_clk = ~ref_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] win(input logic [31:0] s, input logic [31:0] e);
    return {31'h0, (s + 32'h6 >= e) && (s <= e + 32'h6)};
  endfunction
  task automatic wt(input int c);
    repeat (c) @(negedge ref_clk);
  endtask
  task automatic press(input bit f);
    if (f) fsb = 1'b1;
    else mb = 1'b1;
    wt(6);
    fsb = 1'b0;
    mb = 1'b0;
    wt(6);
  endtask
  // Counts flashes in one burst, found between two long dark stretches of the lamp.
  task automatic flashes(input bit sel, output int cnt);
    int low;
    bit prev;
    bit cur;
    bit armed;
    low = 0;
    cnt = 0;
    armed = 0;
    prev = 0;
    repeat (14000) begin
      @(negedge ref_clk);
      cur = sel ? fli : oi;
      if (cur) begin
        if (!prev && armed) cnt++;
        low = 0;
      end else begin
        low++;
        if (low == 1000 * TK) begin
          if (armed) break;
          armed = 1;
        end
      end
      prev = cur;
    end
  endtask
  task wrap_up;
    $display("Comparisons: %0d, mismatches: %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 100000) begin
      n_fail++;
      wrap_up;
    end
  end
  initial begin
    wt(20);
    nrst = 1'b1;
    wt(4);
    check(mode, lfd_pkg::LFD_MODE_PRES_S);
    check(osc, 1'b1);
    check(st_n, 1'b0);
    check(disp, {lfd_pkg::LFD_SYM_DIGIT, 4'h5});
    veh = 1'b1;
    wt(5);
    check({call_out, di}, 2'h3);
    veh = 1'b0;
    wt(5);
    check(call_out, 1'b0);
    lf.open = 1'b1;
    wt(10);
    check(disp.sym, lfd_pkg::LFD_SYM_FAULT);
    flashes(1, n);
    check(n, 1);
    flashes(0, n);
    check(n, 1);
    check(win(stat_w, 32'hc8 * TK), 32'h1);
    lf.open = 1'b0;
    veh = 1'b1;
    wt(10);
    check({di, oi, st_n}, 3'h6);
    check(disp, {lfd_pkg::LFD_SYM_DIGIT, 4'h5});
    flashes(1, n);
    check(n, 1);
    veh = 1'b0;
    lf.shorted = 1'b1;
    flashes(1, n);
    check(n, 2);
    check(win(stat_w, 32'h12c * TK), 32'h1);
    lf.shorted = 1'b0;
    sf = 1'b1;
    wt(4500);
    check(win(stat_w, 32'h64 * TK), 32'h1);
    sf = 1'b0;
    lf.change = 1'b1;
    wt(1);
    lf.change = 1'b0;
    n = 0;
    while (rt !== 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(win(n, 32'h7d0 * TK), 32'h1);
    check(win(stat_w, 32'h190 * TK), 32'h1);
    flashes(1, n);
    check(n, 3);
    check(disp.sym, lfd_pkg::LFD_SYM_DIGIT);
    press(0);
    check(mode, lfd_pkg::LFD_MODE_PRES_L);
    press(0);
    check(mode, lfd_pkg::LFD_MODE_PULSE);
    n0 = call_n;
    veh = 1'b1;
    wt(800);
    check(win(call_w, 32'h7d * TK), 32'h1);
    check(call_n - n0, 32'h1);
    press(0);
    check({mode, call_out}, {lfd_pkg::LFD_MODE_CALL, 1'b1});
    press(0);
    check({mode, osc, call_out, di}, {lfd_pkg::LFD_MODE_OFF, 3'h0});
    check(st_n, 1'b1);
    soo = 1'b1;
    wt(5);
    check(st_n, 1'b0);
    veh = 1'b0;
    press(0);
    check(mode, lfd_pkg::LFD_MODE_PRES_S);
    press(1);
    wt(1000 * TK / 2);
    for (int i = 0; i < 5; i++) begin
      check(disp.sym, syms[i]);
      if (syms[i] == lfd_pkg::LFD_SYM_DIGIT) check(disp.digit, digs[i]);
      wt(1000 * TK);
    end
    wrap_up;
  end
endmodule
bind lfd_channel lfd_channel_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.ref_clk(ref_clk), .nrst(nrst),
  .vehicle_present(vehicle_present), .loop_fault(loop_fault), .status_on_when_off(status_on_when_off),
  .supply_fail(supply_fail), .call_out(call_out), .display(display), .osc_enable(osc_enable),
  .retune(retune), .mode(mode), .status_out_n(status_out_n));
